// [mapc_aux_pins.sv]
/*
 * mode strap decode, external awake, pin 7, activation led, aux clock, reset out.
 * assumes pins synchronous to clk; strap pins stable while rst_n is low.
 */
// Functional notes
// - pin 7 readable and writable general I/O
// - pin 7 input raises maskable edge/level interrupt
// - pin 7 alternatively drives the s/g bit
// - first mode pin: low terminal, high linecard
// - second pin picks linecard variant or awake
// - awake falling edge interrupts, optional reset pulse
// - continuous 7.68 MHz clock, free running
`timescale 1ns/1ps
`include "mapc_cfg.svh"
module mapc_aux_pins import mapc_pkg::*; #(
	parameter int RESET_PULSE_CYC = `MAPC_RESET_PULSE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic modeSelectFirst,
	input wire logic modeSelectSecond,
	output mapc_mode_type opMode,
	input wire mapc_aux_cfg_type auxCfg,
	output mapc_aux_stat_type auxStat,
	input wire logic auxIntClear,
	input wire logic auxPin7In,
	output logic auxPin7Out,
	output logic auxPin7Oe,
	input wire logic sgBitIn,
	input wire logic awakeResetEnable,
	input wire logic awakeIntClear,
	output logic awakeIntReq,
	input wire logic ledAutoMode,
	input wire logic ledSoftLevel,
	input wire logic sActivated,
	output logic activationLedOutput,
	output logic auxClockOutput,
	input wire logic watchdogExpired,
	input wire logic hostResetRequest,
	output logic resetOutputPinOut,
	output logic resetOutputPinOe
);
	// ****************************************************************
	// strap capture
	// ****************************************************************
	mapc_mode_type mode_reg, mode_next;

	// straps are sampled while reset is held, so mode is stable after release
	always_comb begin
		mode_next = mode_reg;
		if (!rst_n) begin
			if (!modeSelectFirst)
				mode_next = MAPC_TERMINAL;
			else if (!modeSelectSecond)
				mode_next = MAPC_TRUNK_LC;
			else
				mode_next = MAPC_SUBSCR_LC;
		end
	end

	always_ff @(posedge clk) begin
		mode_reg <= mode_next;
	end
	assign opMode = mode_reg;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic awakeLevel, awakeFall;
	logic auxLevel, auxFall;

	mapc_edge_sync #(.RESET_LEVEL(1'h1)) awakeSync (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(modeSelectSecond),
		.levelOut(awakeLevel),
		.fallPulse(awakeFall)
	);

	mapc_edge_sync #(.RESET_LEVEL(1'h1)) auxSync (
		.clk(clk),
		.rst_n(rst_n),
		.pinIn(auxPin7In),
		.levelOut(auxLevel),
		.fallPulse(auxFall)
	);

	// ****************************************************************
	// interrupts and reset pulse
	// ****************************************************************
	logic awakeInt_reg, awakeInt_next;
	logic auxInt_reg, auxInt_next;
	logic [15:0] pulseCnt_reg, pulseCnt_next;
	logic awakeEvent, auxEvent;

	// pin 7 as input only when neither s/g drive nor general output is enabled; level mode fires while low
	assign awakeEvent = awakeFall && (mode_reg == MAPC_TERMINAL);
	assign auxEvent = !auxCfg.sgSelect && !auxCfg.outEnable && !auxCfg.intMask
		&& (auxCfg.edgeTrig ? auxFall : !auxLevel);

	// set beats clear so an event in the clearing cycle survives
	always_comb begin
		awakeInt_next = awakeInt_reg;
		auxInt_next = auxInt_reg;
		pulseCnt_next = pulseCnt_reg;
		if (awakeIntClear)
			awakeInt_next = 1'h0;
		if (awakeEvent)
			awakeInt_next = 1'h1;
		if (auxIntClear)
			auxInt_next = 1'h0;
		if (auxEvent)
			auxInt_next = 1'h1;
		if (pulseCnt_reg != 16'h0000)
			pulseCnt_next = pulseCnt_reg - 16'h0001;
		if (awakeEvent && awakeResetEnable)
			pulseCnt_next = 16'(RESET_PULSE_CYC);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awakeInt_reg <= 1'h0;
			auxInt_reg <= 1'h0;
			pulseCnt_reg <= 16'h0000;
		end else begin
			awakeInt_reg <= awakeInt_next;
			auxInt_reg <= auxInt_next;
			pulseCnt_reg <= pulseCnt_next;
		end
	end
	assign awakeIntReq = awakeInt_reg;
	assign auxStat.intReq = auxInt_reg;
	assign auxStat.inLevel = auxLevel;

	// ****************************************************************
	// pin 7, led and reset output
	// ****************************************************************
	logic pin7Out_reg, pin7Out_next;
	logic pin7Oe_reg, pin7Oe_next;
	logic led_reg, led_next;
	logic rstDrv_reg, rstDrv_next;

	// open drain pin: drive low only, release for a high
	always_comb begin
		if (auxCfg.sgSelect) begin
			pin7Oe_next = !sgBitIn;
			pin7Out_next = 1'h0;
		end else begin
			pin7Oe_next = auxCfg.outEnable && !auxCfg.outLevel;
			pin7Out_next = 1'h0;
		end
		led_next = ledAutoMode ? !sActivated : ledSoftLevel;
		rstDrv_next = watchdogExpired || hostResetRequest
			|| (pulseCnt_reg != 16'h0000);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin7Out_reg <= 1'h0;
			pin7Oe_reg <= 1'h0;
			led_reg <= 1'h1;
			rstDrv_reg <= 1'h0;
		end else begin
			pin7Out_reg <= pin7Out_next;
			pin7Oe_reg <= pin7Oe_next;
			led_reg <= led_next;
			rstDrv_reg <= rstDrv_next;
		end
	end
	assign auxPin7Out = pin7Out_reg;
	assign auxPin7Oe = pin7Oe_reg;
	assign activationLedOutput = led_reg;
	assign resetOutputPinOut = `MAPC_RST_PIN_OUT;
	assign resetOutputPinOe = rstDrv_reg;

	// ****************************************************************
	// free running auxiliary clock
	// ****************************************************************
	logic [`MAPC_ACC_WIDTH-1:0] acc_reg, acc_next;
	logic clk768_reg, clk768_next;
	logic accCarry;

	// phase accumulator: truncated step gives an average of about 7.6797 MHz, edges jitter by one cycle,
	// the best a 40 MHz clock can do; never tied to the s interface
	always_comb begin
		{accCarry, acc_next} = {1'h0, acc_reg} + (`MAPC_ACC_WIDTH+1)'(`MAPC_ACC_STEP);
		clk768_next = accCarry ? !clk768_reg : clk768_reg;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_reg <= '0;
			clk768_reg <= `MAPC_RST_AUXCLK;
		end else begin
			acc_reg <= acc_next;
			clk768_reg <= clk768_next;
		end
	end
	assign auxClockOutput = clk768_reg;
endmodule : mapc_aux_pins

// [mapc_cfg.svh]
/*
 * constants for the mode and auxiliary pin block: timing counts and reset values.
 * assumes inclusion by the design module mapc_aux_pins only.
 */
`ifndef MAPC_CFG_SVH
`define MAPC_CFG_SVH

// ****************************************************************
// clocking
// ****************************************************************
`define MAPC_CLK_FREQ_HZ 40000000
`define MAPC_AUXCLK_FREQ_HZ 7680000
// accumulator step for the fractional clock divider: twice the output rate
// as a fraction of 2^16 of clk; 64-bit math, the product overflows 32 bits
`define MAPC_ACC_WIDTH 16
`define MAPC_ACC_STEP ((64'(`MAPC_AUXCLK_FREQ_HZ) * 64'h2 * (64'h1 << `MAPC_ACC_WIDTH)) \
	/ 64'(`MAPC_CLK_FREQ_HZ))

// ****************************************************************
// pulses and reset values
// ****************************************************************
`define MAPC_RESET_PULSE_NS 1000
`define MAPC_RESET_PULSE_CYC \
	(((`MAPC_RESET_PULSE_NS * 40) + 999) / 1000)
`define MAPC_RST_PIN_OUT 1'h0
`define MAPC_RST_AUXCLK 1'h0

`endif

// [mapc_pkg.sv]
/*
 * types shared by the mode and auxiliary pin block.
 * assumes the config header is on the include path.
 */
package mapc_pkg;

	// ****************************************************************
	// operating modes
	// ****************************************************************
	typedef enum logic [1:0] {
		MAPC_TERMINAL = 2'h0,
		MAPC_TRUNK_LC = 2'h1,
		MAPC_SUBSCR_LC = 2'h2
	} mapc_mode_type;

	// ****************************************************************
	// configuration of pin 7
	// ****************************************************************
	typedef struct packed {
		logic sgSelect;    // pin drives the s/g bit
		logic outEnable;   // general output drive
		logic outLevel;    // level written by software
		logic intMask;     // 1 masks the interrupt
		logic edgeTrig;    // 1 edge, 0 level (low active)
	} mapc_aux_cfg_type;

	// status of pin 7 back to software
	typedef struct packed {
		logic inLevel;
		logic intReq;
	} mapc_aux_stat_type;

endpackage : mapc_pkg

// [mapc_edge_sync.sv]
/*
 * two flop synchroniser with a falling edge pulse and a synced level.
 * assumes one clock and a synchronous active low reset.
 */
`timescale 1ns/1ps
module mapc_edge_sync #(
	parameter logic RESET_LEVEL = 1'h1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pinIn,
	output logic levelOut,
	output logic fallPulse
);
	logic meta_reg, meta_next;
	logic sync_reg, sync_next;
	logic prev_reg, prev_next;

	// next values; first stage is read only by the second
	always_comb begin
		meta_next = pinIn;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= RESET_LEVEL;
			sync_reg <= RESET_LEVEL;
			prev_reg <= RESET_LEVEL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign levelOut = sync_reg;
	assign fallPulse = prev_reg & ~sync_reg; // one pulse per edge
endmodule : mapc_edge_sync

// [mapc_aux_pins_properties.sv]
/* checker for the mode and aux pin block: pin drive, led, reset out, interrupts, clock.
 * assumes it is bound to mapc_aux_pins and sees only that module's ports. */
`timescale 1ns/1ps
module mapc_aux_pins_properties import mapc_pkg::*; #(
	parameter int RESET_PULSE_CYC = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic modeSelectSecond,
	input wire mapc_mode_type opMode,
	input wire mapc_aux_cfg_type auxCfg,
	input wire mapc_aux_stat_type auxStat,
	input wire logic auxIntClear,
	input wire logic auxPin7In,
	input wire logic auxPin7Out,
	input wire logic auxPin7Oe,
	input wire logic sgBitIn,
	input wire logic awakeResetEnable,
	input wire logic awakeIntReq,
	input wire logic ledAutoMode,
	input wire logic ledSoftLevel,
	input wire logic sActivated,
	input wire logic activationLedOutput,
	input wire logic auxClockOutput,
	input wire logic watchdogExpired,
	input wire logic hostResetRequest,
	input wire logic resetOutputPinOut,
	input wire logic resetOutputPinOe
);
	// ****************
	// properties
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// open drain pins only ever pull low; registered outputs skip the first edge after reset
	AST_OD_LOW: assert property (!auxPin7Out && !resetOutputPinOut)
		else $error("open drain output driven high");
	AST_SG_DRIVE: assert property ($past(rst_n) && $past(auxCfg.sgSelect) |->
		auxPin7Oe == !$past(sgBitIn)) else $error("pin 7 does not follow the s/g bit");
	AST_GPIO_DRIVE: assert property ($past(rst_n) && !$past(auxCfg.sgSelect) |->
		auxPin7Oe == ($past(auxCfg.outEnable) && !$past(auxCfg.outLevel)))
		else $error("pin 7 output level wrong");
	AST_LED: assert property ($past(rst_n) |-> activationLedOutput ==
		($past(ledAutoMode) ? !$past(sActivated) : $past(ledSoftLevel))) else $error("led wrong");
	AST_RESET_OUTPUT_PIN_REQ: assert property ($past(rst_n) && ($past(watchdogExpired) ||
		$past(hostResetRequest)) |-> resetOutputPinOe) else $error("reset output not pulled");
	// interrupt flags: three edges through the two synchroniser flops and the interrupt flag register
	AST_AUX_EDGE: assert property ($fell(auxPin7In) && auxCfg == 5'h01 && !auxIntClear
		|-> ##[3:4] auxStat.intReq) else $error("pin 7 fall gave no interrupt");
	AST_AUX_MASK: assert property ($rose(auxStat.intReq) |-> !$past(auxCfg.intMask))
		else $error("masked pin 7 interrupt raised");
	AST_AWAKE_INT: assert property ($fell(modeSelectSecond) && opMode == MAPC_TERMINAL
		|-> ##[3:4] awakeIntReq) else $error("awake fall gave no interrupt");
	AST_AWAKE_LC: assert property (opMode != MAPC_TERMINAL |-> !awakeIntReq)
		else $error("awake interrupt in linecard mode");
	AST_WAKE_PULSE: assert property ($rose(awakeIntReq) && awakeResetEnable
		|-> ##[0:3] resetOutputPinOe) else $error("awake gave no reset pulse");
	// the divider toggles every two or three cycles, so four edges always hold a change
	AST_CLK_RUN: assert property ($past(rst_n, 3) |-> ##[0:3] $changed(auxClockOutput))
		else $error("aux clock stopped");
endmodule : mapc_aux_pins_properties

// [mapc_board_model.sv]
/* board side of the block: pull-ups on pin 7 and the reset line, plus an external pull-down.
 * assumes the enables are high while a party pulls its line low. */
`timescale 1ns/1ps
module mapc_board_model (
	input wire logic auxPin7Oe,
	input wire logic extPullLow,
	input wire logic resetOutputPinOe,
	output logic pin7Level,
	output logic resetLevel
);
	// wired-and with pull-ups: any party pulling low wins, released lines read high
	assign pin7Level = !(auxPin7Oe || extPullLow);
	assign resetLevel = !resetOutputPinOe;
endmodule : mapc_board_model

// [test_mapc_aux_pins.sv]
/* self-checking bench for the mode and aux pin block.
 * assumes the package, config header, design and board model are compiled first. */
`timescale 1ns/1ps
module test_mapc_aux_pins import mapc_pkg::*; ();
	// ****************
	// bench
	// ****************
	localparam int PULSE = 4;
	logic clk = 1'h0, rst_n = 1'h0, modeSelectFirst = 1'h0, modeSelectSecond = 1'h1;
	logic auxIntClear = 1'h0, sgBitIn = 1'h0, awakeResetEnable = 1'h0, awakeIntClear = 1'h0;
	logic ledAutoMode = 1'h0, ledSoftLevel = 1'h0, sActivated = 1'h0, extPullLow = 1'h0;
	logic watchdogExpired = 1'h0, hostResetRequest = 1'h0, resetLevel, prevClk;
	logic auxPin7In, auxPin7Out, auxPin7Oe, awakeIntReq, activationLedOutput, auxClockOutput;
	logic resetOutputPinOut, resetOutputPinOe;
	mapc_aux_cfg_type auxCfg = 5'h00;
	mapc_aux_stat_type auxStat;
	mapc_mode_type opMode;
	int n_mismatch = 0, n_tests = 0, k, cnt;
	always #12.5 clk = ~clk;
	mapc_aux_pins #(.RESET_PULSE_CYC(PULSE)) mapc_aux_pins_inst (.*);
	mapc_board_model mapc_board_model_inst (.auxPin7Oe(auxPin7Oe), .extPullLow(extPullLow),
		.resetOutputPinOe(resetOutputPinOe), .pin7Level(auxPin7In), .resetLevel(resetLevel));
	// drives land by nba on a rising edge; looks sample 1 ns later once outputs settled
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask : step
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : look
	task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// straps are only captured while reset is low
	task automatic doReset(input logic f, input logic s);
		step(1);
		{modeSelectFirst, modeSelectSecond, rst_n} <= {f, s, 1'h0};
		step(3);
		rst_n <= 1'h1;
	endtask : doReset
	initial begin
		for (k = 0; k < 4; k++) begin
			doReset(k[1], k[0]);
			look(2);
			chk("opMode", k[1] ? (k[0] ? MAPC_SUBSCR_LC : MAPC_TRUNK_LC) : MAPC_TERMINAL, opMode);
		end
		step(1);
		modeSelectSecond <= 1'h0;
		look(6);
		chk("awakeIntReq", 2'h0, awakeIntReq);
		$display("strap test done");
		// masked general output and s/g drive; the last pass leaves pin 7 released high
		for (k = 0; k < 4; k++) begin
			step(1);
			{auxCfg, sgBitIn} <= {k[1], 1'h1, !k[0], 2'h2, k[0]};
			look(4);
			chk("pin7", k[1] ? k[0] : !k[0], auxStat.inLevel);
		end
		$display("pin 7 io test done");
		step(1);
		{auxCfg, extPullLow} <= {5'h01, 1'h1};
		look(5);
		chk("intReq", 2'h1, auxStat.intReq);
		step(1);
		auxIntClear <= 1'h1;
		step(1);
		auxIntClear <= 1'h0;
		look(4);
		chk("intReq", 2'h0, auxStat.intReq);
		step(1);
		{auxCfg, extPullLow} <= {5'h03, 1'h0};
		step(4);
		extPullLow <= 1'h1;
		look(6);
		chk("intReq", 2'h0, auxStat.intReq);
		step(1);
		auxCfg <= 5'h00;
		look(5);
		chk("intReq", 2'h1, auxStat.intReq);
		$display("pin 7 interrupt test done");
		doReset(1'h0, 1'h1);
		step(2);
		{awakeResetEnable, modeSelectSecond} <= 2'h2;
		cnt = 0;
		repeat (20) begin
			look(1);
			cnt += !resetLevel;
		end
		chk("awakeIntReq", 2'h1, awakeIntReq);
		chk("pulseLen", 2'h1, {1'h0, cnt == PULSE});
		step(1);
		awakeIntClear <= 1'h1;
		step(1);
		awakeIntClear <= 1'h0;
		look(2);
		chk("awakeIntReq", 2'h0, awakeIntReq);
		$display("awake test done");
		for (k = 0; k < 11; k++) begin
			step(1);
			{ledAutoMode, sActivated, ledSoftLevel} <= k[2:0];
			{watchdogExpired, hostResetRequest} <= (k > 7) ? k[1:0] + 2'h1 : 2'h0;
			look(2);
			chk("led", k[2] ? !k[1] : k[0], activationLedOutput);
			chk("reset_output_pin", {1'h0, k < 8}, resetLevel);
		end
		$display("led and reset test done");
		// 1000 cycles at 40 MHz hold 384 edges of 7.68 MHz, one cycle of jitter allowed
		cnt = 0;
		repeat (1000) begin
			prevClk = auxClockOutput;
			look(1);
			cnt += (auxClockOutput !== prevClk);
		end
		chk("clkEdges", 2'h1, {1'h0, cnt >= 383 && cnt <= 385});
		$display("clock test done");
		test_done();
	end
	// cut a hang short at 4000 cycles, well beyond the roughly 1150 cycles the run needs
	initial begin
		#100us;
		n_mismatch++;
		$display("Error run expected finish seen timeout");
		test_done();
	end
endmodule : test_mapc_aux_pins
bind mapc_aux_pins mapc_aux_pins_properties #(.RESET_PULSE_CYC(RESET_PULSE_CYC))
	mapc_aux_pins_properties_inst (.*);
